// ### logic/ofpi_pkg.sv
// shared constants, types and decode functions of the p2/frame-closing pilot inserter
package ofpi_pkg;

  // ---------------------------------------------------------------
  // widths and configuration types
  // ---------------------------------------------------------------
  localparam int CW = 16;
  localparam int KW = 15;
  localparam int SW = 5;

  typedef enum logic [2:0] {FFT_1K, FFT_2K, FFT_4K, FFT_8K, FFT_16K, FFT_32K} ofpi_fft_e;
  typedef enum logic [1:0] {CELL_DATA, CELL_PILOT, CELL_RESERVED} ofpi_cell_e;

  // ---------------------------------------------------------------
  // carrier geometry
  // ---------------------------------------------------------------
  localparam logic [KW-1:0] LAST_1K = 15'd852;
  localparam logic [KW-1:0] LAST_2K = 15'd1704;
  localparam logic [KW-1:0] LAST_4K = 15'd3408;
  localparam logic [KW-1:0] LAST_8K = 15'd6816;
  localparam logic [KW-1:0] LAST_16K = 15'd13632;
  localparam logic [KW-1:0] LAST_32K = 15'd27264;
  localparam logic [KW-1:0] EXT_8K = 15'd48;
  localparam logic [KW-1:0] EXT_16K = 15'd144;
  localparam logic [KW-1:0] EXT_32K = 15'd288;
  localparam logic [KW-1:0] EXT_NONE = 15'd0;
  localparam logic [SW-1:0] P2_SPACING_STD = 5'd3;
  localparam logic [SW-1:0] P2_SPACING_WIDE = 5'd6;
  localparam logic [KW-1:0] EDGE_GAP_1 = 15'd1;
  localparam logic [KW-1:0] EDGE_GAP_2 = 15'd2;

  // ---------------------------------------------------------------
  // reference sequence generator
  // ---------------------------------------------------------------
  localparam int PRBS_W = 11;
  localparam logic [PRBS_W-1:0] PRBS_INIT = 11'h7FF;
  localparam int PRBS_TAP = 2;

  // ---------------------------------------------------------------
  // expected per-symbol counts at the 8k, 16k and 32k fft sizes
  // ---------------------------------------------------------------
  localparam logic [KW-1:0] REG_32K_MISO_N = 15'd9089;
  localparam logic [KW-1:0] REG_32K_MISO_E = 15'd9281;
  localparam logic [KW-1:0] REG_32K_SISO_N = 15'd4545;
  localparam logic [KW-1:0] PAD_8K = 15'd96;
  localparam logic [KW-1:0] PAD_16K = 15'd288;
  localparam logic [KW-1:0] PAD_32K = 15'd576;
  localparam logic [KW-1:0] EXTRA_8K = 15'd64;
  localparam logic [KW-1:0] EXTRA_16K = 15'd192;
  localparam logic [KW-1:0] EXTRA_32K_SISO = 15'd480;
  localparam logic [KW-1:0] EXTRA_32K_MISO = 15'd384;

  // ---------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------
  function automatic logic [KW-1:0] fft_last_normal(input ofpi_fft_e f);
    unique case (f)
      FFT_1K: fft_last_normal = LAST_1K;
      FFT_2K: fft_last_normal = LAST_2K;
      FFT_4K: fft_last_normal = LAST_4K;
      FFT_8K: fft_last_normal = LAST_8K;
      FFT_16K: fft_last_normal = LAST_16K;
      default: fft_last_normal = LAST_32K;
    endcase
  endfunction

  // extension carriers per side; zero where extended mode is not offered
  function automatic logic [KW-1:0] fft_ext(input ofpi_fft_e f);
    unique case (f)
      FFT_8K: fft_ext = EXT_8K;
      FFT_16K: fft_ext = EXT_16K;
      FFT_32K: fft_ext = EXT_32K;
      default: fft_ext = EXT_NONE;
    endcase
  endfunction

endpackage

// ### logic/ofpi_fifo.sv
// cell fifo between the inserter and the ifft stage
`timescale 1ns/1ps
module ofpi_fifo
  import ofpi_pkg::*;
#(
  parameter int WIDTH = 34,
  parameter int DEPTH = 32
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_comb
  begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push)
    begin
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
    end
    if (pop)
    begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop)
    begin
      cnt_d = cnt_q + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage carries no reset; only written slots are ever read
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule

// ### logic/ofpi_prbs.sv
// pilot reference sequence generator, one sample per step
`timescale 1ns/1ps
module ofpi_prbs
  import ofpi_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic load,
  input wire logic step,
  output logic seq_bit
);

  logic [PRBS_W-1:0] lfsr_q, lfsr_d;

  assign seq_bit = lfsr_q[0];

  always_comb
  begin
    lfsr_d = lfsr_q;
    if (load)
    begin
      lfsr_d = PRBS_INIT;
    end
    else if (step)
    begin
      lfsr_d = {lfsr_q[0] ^ lfsr_q[PRBS_TAP], lfsr_q[PRBS_W-1:1]};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      lfsr_q <= PRBS_INIT;
    end
    else
    begin
      lfsr_q <= lfsr_d;
    end
  end

endmodule

// ### logic/ofpi_inserter.sv
// p2 and frame-closing symbol pilot inserter, cell stream in carrier order
//
// Functional notes
// RQ1: p2 padding region carriers are all pilots
// RQ2: p2 grid spacing 3, 6 at 32k siso
// RQ3: regular p2 count equal siso/miso except 32k
// RQ4: padding spans 96, 288, 576 carriers
// RQ5: off-grid padding pilots 64, 192, 480/384
// RQ6: miso partner pilot beside isolated reserved tone
// RQ7: miso adds four pilots near edges
// RQ8: p2 data cell count same both modes
// RQ9: frame-closing pilot on every dx multiple; a reserved tone on a dx multiple stays reserved, not a pilot
// RQ10: optional extra pilot below last carrier
// RQ11: datapath headroom for 8/3 boost
// RQ12: edge pilots use scattered pilot boost
// RQ13: group 2 inverts alternate dx carriers
// RQ14: group 2 inverts alternate p2 grid multiples
// RQ15: group 2 inverts edge pilots alternate symbols
// RQ16: edge inversion overrides frame-closing inversion
// RQ17: miso fills two carriers at band ends
// RQ18: extended mode only at 8k, 16k, 32k
// RQ19: normal mode starts sequence at extension index
// RQ20: extra pilot and boosts come from tables
// RQ21: one tagged cell per handshake, ascending
`timescale 1ns/1ps
module ofpi_inserter
  import ofpi_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire ofpi_fft_e cfg_fft_size,
  input wire logic cfg_ext_mode,
  input wire logic cfg_miso,
  input wire logic cfg_group2,
  input wire logic [SW-1:0] cfg_sp_carrier_spacing,
  input wire logic cfg_fc_extra_pilot,
  input wire logic [CW-1:0] cfg_sp_boost,
  input wire logic [CW-1:0] cfg_fc_boost,
  input wire logic [CW-1:0] cfg_p2_boost,
  input wire logic sym_start,
  input wire logic sym_is_fc,
  input wire logic sym_index_odd,
  output logic [KW-1:0] tr_probe_idx,
  output logic [KW-1:0] tr_pair_idx,
  input wire logic tr_hit,
  input wire logic tr_pair_hit,
  input wire logic din_valid,
  output logic din_ready,
  input wire logic [CW-1:0] din_re,
  input wire logic [CW-1:0] din_im,
  output logic cell_valid,
  input wire logic cell_ready,
  output logic [1:0] cell_type,
  output logic [CW-1:0] cell_re,
  output logic [CW-1:0] cell_im,
  output logic busy,
  output logic sym_done,
  output logic [KW-1:0] p2_data_cell_count,
  output logic [KW-1:0] regular_pilot_count,
  output logic [KW-1:0] pad_carrier_count,
  output logic [KW-1:0] extra_pad_pilot_count
);

  localparam int FW = 2 + 2 * CW;

  typedef enum logic [1:0] {ST_IDLE, ST_PRIME, ST_RUN} ofpi_state_e;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ofpi_state_e state_q, state_d;
  logic fc_q, fc_d;
  logic [KW-1:0] k_q, k_d, prime_q, prime_d;
  logic [SW-1:0] p2_mod_q, p2_mod_d, sp_mod_q, sp_mod_d;
  logic p2_par_q, p2_par_d, sp_par_q, sp_par_d;
  logic [KW-1:0] c_data_q, c_data_d, c_reg_q, c_reg_d, c_pad_q, c_pad_d, c_xtr_q, c_xtr_d;
  logic [KW-1:0] s_data_q, s_data_d, s_reg_q, s_reg_d, s_pad_q, s_pad_d, s_xtr_q, s_xtr_d;
  logic done_q, done_d;

  // ---------------------------------------------------------------
  // carrier classification
  // ---------------------------------------------------------------
  logic [KW-1:0] ext_act, last_k;
  logic [SW-1:0] p2_spacing;
  logic in_pad, on_grid, edge_fill, partner, fc_edge, fc_pilot;
  logic is_pilot, is_res, invert, seq_bit, advance, push, fifo_ready, last_cell;
  logic [CW-1:0] amp, pil_val;
  ofpi_cell_e ctype;

  // extension width collapses to zero below 8k
  // RQ18 extended only large
  assign ext_act = cfg_ext_mode ? fft_ext(cfg_fft_size) : EXT_NONE;
  assign last_k = fft_last_normal(cfg_fft_size) + ext_act + ext_act;
  // RQ2 grid spacing select
  assign p2_spacing = (cfg_fft_size == FFT_32K && !cfg_miso) ? P2_SPACING_WIDE : P2_SPACING_STD;

  // RQ1 padding region fill
  assign in_pad = (ext_act != EXT_NONE) && ((k_q < ext_act) || (k_q > last_k - ext_act));
  assign on_grid = (p2_mod_q == '0);
  // RQ7 edge pilot pairs
  // RQ17 band end fill
  assign edge_fill = cfg_miso &&
    ((k_q == ext_act + EDGE_GAP_1) || (k_q == ext_act + EDGE_GAP_2) ||
     (k_q == last_k - ext_act - EDGE_GAP_1) || (k_q == last_k - ext_act - EDGE_GAP_2));
  // RQ6 reserved tone partner
  assign partner = cfg_miso && !tr_hit && tr_pair_hit;
  assign tr_probe_idx = k_q;
  assign tr_pair_idx = {k_q[KW-1:1], ~k_q[0]};

  assign fc_edge = (k_q == '0) || (k_q == last_k);
  // RQ9 dx multiples
  // RQ10 extra closing pilot
  assign fc_pilot = (sp_mod_q == '0) || (cfg_fc_extra_pilot && (k_q == last_k - EDGE_GAP_1));

  always_comb
  begin
    is_res = 1'b0;
    is_pilot = 1'b0;
    invert = 1'b0;
    amp = cfg_p2_boost;
    if (!fc_q)
    begin
      // padding wins over reserved tones so the edge band stays data-free
      is_pilot = in_pad || (!tr_hit && (on_grid || edge_fill || partner));
      is_res = !in_pad && tr_hit;
      // RQ14 alternate grid inversion
      invert = cfg_group2 && p2_par_q;
    end
    else if (fc_edge)
    begin
      is_pilot = 1'b1;
      // RQ12 edge uses scattered boost
      amp = cfg_sp_boost;
      // RQ15 alternate symbol edges
      // RQ16 edge rule precedence
      invert = cfg_group2 && sym_index_odd;
    end
    else
    begin
      is_pilot = !tr_hit && fc_pilot;
      is_res = tr_hit;
      amp = cfg_fc_boost;
      // RQ13 alternate dx inversion
      invert = cfg_group2 && sp_par_q;
    end
  end

  // boosts arrive as table values in signed 3.12, so 8/3 keeps one bit spare
  // RQ11 boost headroom
  // RQ20 tabled boosts
  assign pil_val = (seq_bit ^ invert) ? ({CW{1'b0}} - amp) : amp;
  assign ctype = is_res ? CELL_RESERVED : (is_pilot ? CELL_PILOT : CELL_DATA);

  // RQ21 cell handshake
  assign advance = (state_q == ST_RUN) && fifo_ready && (ctype != CELL_DATA || din_valid);
  assign push = advance;
  assign din_ready = (state_q == ST_RUN) && fifo_ready && (ctype == CELL_DATA);
  assign last_cell = (k_q == last_k);
  assign busy = (state_q != ST_IDLE);
  assign sym_done = done_q;
  assign p2_data_cell_count = s_data_q;
  assign regular_pilot_count = s_reg_q;
  assign pad_carrier_count = s_pad_q;
  assign extra_pad_pilot_count = s_xtr_q;

  // ---------------------------------------------------------------
  // sequencer and counters
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    fc_d = fc_q;
    k_d = k_q;
    prime_d = prime_q;
    p2_mod_d = p2_mod_q;
    p2_par_d = p2_par_q;
    sp_mod_d = sp_mod_q;
    sp_par_d = sp_par_q;
    c_data_d = c_data_q;
    c_reg_d = c_reg_q;
    c_pad_d = c_pad_q;
    c_xtr_d = c_xtr_q;
    s_data_d = s_data_q;
    s_reg_d = s_reg_q;
    s_pad_d = s_pad_q;
    s_xtr_d = s_xtr_q;
    done_d = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        // a start while busy is dropped; config must hold for the symbol
        if (sym_start)
        begin
          fc_d = sym_is_fc;
          k_d = '0;
          p2_mod_d = '0;
          p2_par_d = 1'b0;
          sp_mod_d = '0;
          sp_par_d = 1'b0;
          c_data_d = '0;
          c_reg_d = '0;
          c_pad_d = '0;
          c_xtr_d = '0;
          // RQ19 sequence offset in normal mode
          prime_d = cfg_ext_mode ? EXT_NONE : fft_ext(cfg_fft_size);
          state_d = ST_PRIME;
        end
      end
      ST_PRIME:
      begin
        if (prime_q == '0)
        begin
          state_d = ST_RUN;
        end
        else
        begin
          prime_d = prime_q - 1'b1;
        end
      end
      ST_RUN:
      begin
        if (advance)
        begin
          k_d = k_q + 1'b1;
          p2_mod_d = (p2_mod_q == p2_spacing - 1'b1) ? '0 : p2_mod_q + 1'b1;
          p2_par_d = (p2_mod_q == p2_spacing - 1'b1) ? ~p2_par_q : p2_par_q;
          sp_mod_d = (sp_mod_q == cfg_sp_carrier_spacing - 1'b1) ? '0 : sp_mod_q + 1'b1;
          sp_par_d = (sp_mod_q == cfg_sp_carrier_spacing - 1'b1) ? ~sp_par_q : sp_par_q;
          // RQ8 data cell tally
          if (ctype == CELL_DATA)
          begin
            c_data_d = c_data_q + 1'b1;
          end
          // RQ3 regular grid tally
          if (!fc_q && on_grid)
          begin
            c_reg_d = c_reg_q + 1'b1;
          end
          // RQ4 padding span tally
          // RQ5 off-grid padding tally
          if (!fc_q && in_pad)
          begin
            c_pad_d = c_pad_q + 1'b1;
            if (!on_grid)
            begin
              c_xtr_d = c_xtr_q + 1'b1;
            end
          end
          if (last_cell)
          begin
            s_data_d = c_data_d;
            s_reg_d = c_reg_d;
            s_pad_d = c_pad_d;
            s_xtr_d = c_xtr_d;
            done_d = 1'b1;
            state_d = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      fc_q <= 1'b0;
      k_q <= '0;
      prime_q <= '0;
      p2_mod_q <= '0;
      p2_par_q <= 1'b0;
      sp_mod_q <= '0;
      sp_par_q <= 1'b0;
      c_data_q <= '0;
      c_reg_q <= '0;
      c_pad_q <= '0;
      c_xtr_q <= '0;
      s_data_q <= '0;
      s_reg_q <= '0;
      s_pad_q <= '0;
      s_xtr_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      fc_q <= fc_d;
      k_q <= k_d;
      prime_q <= prime_d;
      p2_mod_q <= p2_mod_d;
      p2_par_q <= p2_par_d;
      sp_mod_q <= sp_mod_d;
      sp_par_q <= sp_par_d;
      c_data_q <= c_data_d;
      c_reg_q <= c_reg_d;
      c_pad_q <= c_pad_d;
      c_xtr_q <= c_xtr_d;
      s_data_q <= s_data_d;
      s_reg_q <= s_reg_d;
      s_pad_q <= s_pad_d;
      s_xtr_q <= s_xtr_d;
      done_q <= done_d;
    end
  end

  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  ofpi_prbs u_prbs (
    .mclk(mclk),
    .srst(srst),
    .load(state_q == ST_IDLE && sym_start),
    .step(advance || (state_q == ST_PRIME && prime_q != '0)),
    .seq_bit(seq_bit)
  );

  ofpi_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({ctype, (ctype == CELL_DATA) ? din_re : (is_pilot ? pil_val : {CW{1'b0}}),
              (ctype == CELL_DATA) ? din_im : {CW{1'b0}}}),
    .out_valid(cell_valid),
    .out_ready(cell_ready),
    .out_data({cell_type, cell_re, cell_im})
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_pad_pilot: assert property (@(posedge mclk) disable iff (srst) // RQ1
    push && !fc_q && in_pad |-> ctype == CELL_PILOT)
    else $error("padding carrier not a pilot");
  chk_grid_wide: assert property (@(posedge mclk) disable iff (srst) // RQ2
    push && !fc_q && cfg_fft_size == FFT_32K && !cfg_miso && !in_pad && !tr_hit &&
    k_q > ext_act + EDGE_GAP_2 && k_q < last_k - ext_act - EDGE_GAP_2 && !partner
    |-> (ctype == CELL_PILOT) == (k_q % P2_SPACING_WIDE == 0))
    else $error("wide p2 grid misplaced");
  chk_reg_miso: assert property (@(posedge mclk) disable iff (srst) // RQ3
    done_q && !fc_q && cfg_miso && cfg_fft_size == FFT_32K
    |-> s_reg_q == (cfg_ext_mode ? REG_32K_MISO_E : REG_32K_MISO_N))
    else $error("regular p2 pilot count wrong");
  chk_pad_span: assert property (@(posedge mclk) disable iff (srst) // RQ4
    done_q && !fc_q && cfg_ext_mode && cfg_fft_size == FFT_32K |-> s_pad_q == PAD_32K)
    else $error("padding span wrong");
  chk_extra_cnt: assert property (@(posedge mclk) disable iff (srst) // RQ5
    done_q && !fc_q && cfg_ext_mode && cfg_fft_size == FFT_32K
    |-> s_xtr_q == (cfg_miso ? EXTRA_32K_MISO : EXTRA_32K_SISO))
    else $error("off-grid padding count wrong");
  chk_tr_partner: assert property (@(posedge mclk) disable iff (srst) // RQ6
    push && !fc_q && cfg_miso && tr_pair_hit && !tr_hit |-> ctype == CELL_PILOT)
    else $error("reserved tone partner missing");
  chk_fc_grid: assert property (@(posedge mclk) disable iff (srst) // RQ9
    push && fc_q && !tr_hit && sp_mod_q == '0 |-> ctype == CELL_PILOT)
    else $error("closing pilot missing");
  chk_edge_inv: assert property (@(posedge mclk) disable iff (srst) // RQ16
    push && fc_q && fc_edge && cfg_group2 |-> pil_val == ((seq_bit ^ sym_index_odd) ?
    ({CW{1'b0}} - cfg_sp_boost) : cfg_sp_boost))
    else $error("edge pilot inversion wrong");
  chk_prime_len: assert property (@(posedge mclk) disable iff (srst) // RQ19
    state_q == ST_IDLE && sym_start && !cfg_ext_mode && cfg_fft_size == FFT_8K
    |=> state_q == ST_PRIME ##48 state_q == ST_PRIME ##1 state_q == ST_RUN)
    else $error("sequence offset length wrong");
  chk_cell_hold: assert property (@(posedge mclk) disable iff (srst) // RQ21
    cell_valid && !cell_ready |=> cell_valid && $stable(cell_type) && $stable(cell_re))
    else $error("cell dropped under back-pressure");

endmodule

// ### verif/ofpi_partner.sv
// far side of the inserter: cell source, reserved-tone table, stalling cell sink
`timescale 1ns/1ps
module ofpi_partner
  import ofpi_pkg::*;
(
  input wire logic mclk,
  input wire logic [KW-1:0] tr_probe_idx,
  input wire logic [KW-1:0] tr_pair_idx,
  output logic tr_hit,
  output logic tr_pair_hit,
  output logic din_valid,
  input wire logic din_ready,
  output logic [CW-1:0] din_re,
  output logic [CW-1:0] din_im,
  input wire logic cell_valid,
  output logic cell_ready,
  input wire logic [1:0] cell_type,
  input wire logic [CW-1:0] cell_re,
  input wire logic [CW-1:0] cell_im,
  input wire logic [KW-1:0] ofs,
  input wire logic [KW-1:0] plast,
  input wire logic [CW-1:0] amp,
  input wire logic [CW-1:0] eamp
);
  int k, n_pilot, n_data, n_rsv, n_bad;
  logic [CW-1:0] seq = 16'h0000;
  logic [CW-1:0] exp_d = 16'h0000;
  logic [9:0] cyc = 10'h000;
  logic took = 1'b0;
  logic [CW-1:0] a;
  logic neg [0:32767];

  // ----------------------------------------
  // reserved tones
  // ----------------------------------------
  // one lone tone and one adjacent pair, moved with the band in extended mode
  function automatic logic tone(input logic [KW-1:0] c);
    tone = (c == 15'h000A) || (c == 15'h0016) || (c == 15'h0017);
  endfunction
  assign tr_hit = tone(tr_probe_idx - ofs);
  assign tr_pair_hit = tone(tr_pair_idx - ofs);

  task automatic clear();
    k = 0;
    n_pilot = 0;
    n_data = 0;
    n_rsv = 0;
    n_bad = 0;
  endtask

  initial
  begin
    clear();
    din_valid = 1'b0;
    din_re = 16'h0000;
    din_im = 16'hFFFF;
    cell_ready = 1'b0;
  end

  // ----------------------------------------
  // cell sink and tally
  // ----------------------------------------
  always @(posedge mclk)
  begin
    took = din_valid && din_ready;
    a = (k == 0 || k == plast) ? eamp : amp;
    if (cell_valid && cell_ready)
    begin
      case (cell_type)
        2'h0: n_bad += cell_re !== exp_d || cell_im !== ~exp_d;
        2'h1: n_bad += (cell_re !== a && cell_re !== -a) || cell_im !== 16'h0000;
        2'h2: n_bad += cell_re !== 16'h0000 || cell_im !== 16'h0000;
        default: n_bad++;
      endcase
      n_data += cell_type == 2'h0;
      n_pilot += cell_type == 2'h1;
      n_rsv += cell_type == 2'h2;
      exp_d += {15'h0000, cell_type == 2'h0};
      neg[k] = cell_re[CW-1];
      k++;
    end
  end

  // ----------------------------------------
  // source and sink drive
  // ----------------------------------------
  always @(negedge mclk)
  begin
    cyc <= cyc + 10'h001;
    if (took)
    begin
      seq = seq + 16'h0001;
    end
    // a pending word holds until taken; an idle bus shows the inverse
    if (took || !din_valid)
    begin
      din_valid <= cyc[4:2] != 3'h7;
      din_re <= (cyc[4:2] != 3'h7) ? seq : ~seq;
      din_im <= (cyc[4:2] != 3'h7) ? ~seq : seq;
    end
    // sink stall of 64 cycles, long enough to fill the fifo
    cell_ready <= cyc[9:6] != 4'h0;
  end
endmodule

// ### verif/ofpi_inserter_tb.sv
// self-checking testbench of the p2 and frame-closing pilot inserter
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("mismatch %s expected %0d seen %0d", nm, e, g); \
    end \
  end
module ofpi_inserter_tb
  import ofpi_pkg::*;
;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  ofpi_fft_e cfg_fft_size = FFT_1K;
  logic cfg_ext_mode = 1'b0;
  logic cfg_miso = 1'b0;
  logic cfg_group2 = 1'b0;
  logic [SW-1:0] cfg_sp_carrier_spacing = 5'h03;
  logic cfg_fc_extra_pilot = 1'b0;
  logic [CW-1:0] cfg_sp_boost = 16'h1000;
  logic [CW-1:0] cfg_fc_boost = 16'h1800;
  logic [CW-1:0] cfg_p2_boost = 16'h2AAB;
  logic sym_start = 1'b0;
  logic sym_is_fc = 1'b0;
  logic sym_index_odd = 1'b0;
  logic tr_hit, tr_pair_hit, din_valid, din_ready, cell_valid, cell_ready, busy, sym_done;
  logic [KW-1:0] tr_probe_idx, tr_pair_idx, p2_data_cell_count, regular_pilot_count;
  logic [KW-1:0] pad_carrier_count, extra_pad_pilot_count;
  logic [KW-1:0] ofs = 15'h0000;
  logic [KW-1:0] plast = 15'h0000;
  logic [CW-1:0] amp = 16'h0000;
  logic [CW-1:0] eamp = 16'h0000;
  logic [CW-1:0] din_re, din_im, cell_re, cell_im;
  logic [1:0] cell_type;
  int miscompares = 0;
  int compares = 0;
  int pd;
  logic sa [0:32767];
  logic sb [0:32767];

  always #50 mclk = ~mclk;

  ofpi_inserter #(.FIFO_DEPTH(32)) DUT (.mclk, .srst, .cfg_fft_size, .cfg_ext_mode,
    .cfg_miso, .cfg_group2, .cfg_sp_carrier_spacing, .cfg_fc_extra_pilot, .cfg_sp_boost,
    .cfg_fc_boost, .cfg_p2_boost, .sym_start, .sym_is_fc, .sym_index_odd, .tr_probe_idx,
    .tr_pair_idx, .tr_hit, .tr_pair_hit, .din_valid, .din_ready, .din_re, .din_im,
    .cell_valid, .cell_ready, .cell_type, .cell_re, .cell_im, .busy, .sym_done,
    .p2_data_cell_count, .regular_pilot_count, .pad_carrier_count, .extra_pad_pilot_count);

  ofpi_partner far (.mclk, .tr_probe_idx, .tr_pair_idx, .tr_hit, .tr_pair_hit, .din_valid,
    .din_ready, .din_re, .din_im, .cell_valid, .cell_ready, .cell_type, .cell_re, .cell_im,
    .ofs, .plast, .amp, .eamp);

  // ----------------------------------------
  // verdict and wait limits
  // ----------------------------------------
  task automatic give_verdict();
    if (miscompares == 0 && compares > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic limit(input int i, input int n);
    if (i >= n)
    begin
      miscompares++;
      give_verdict();
    end
  endtask

  // ----------------------------------------
  // one symbol; fl = {ext, miso, group2, fc, extra, odd}
  // ----------------------------------------
  task automatic sym(input ofpi_fft_e f, input logic [5:0] fl, input int last, ex, sp);
    int pil, i;
    pil = fl[2] ? last / sp + 1 + fl[1] : last / sp + 1 + 2 * ex - 2 * ex / sp + 5 * fl[4];
    @(negedge mclk);
    far.clear();
    {cfg_ext_mode, cfg_miso, cfg_group2, sym_is_fc, cfg_fc_extra_pilot, sym_index_odd} = fl;
    cfg_fft_size = f;
    cfg_sp_carrier_spacing = sp[SW-1:0];
    ofs = ex[KW-1:0];
    plast = last[KW-1:0];
    amp = fl[2] ? cfg_fc_boost : cfg_p2_boost;
    eamp = fl[2] ? cfg_sp_boost : cfg_p2_boost;
    sym_start = 1'b1;
    @(negedge mclk);
    sym_start = 1'b0;
    repeat (3) @(negedge mclk);
    // a start while busy must leave the symbol alone
    sym_start = 1'b1;
    @(negedge mclk);
    sym_start = 1'b0;
    for (i = 0; i < 40000 && sym_done !== 1'b1; i++) @(negedge mclk);
    limit(i, 40000);
    @(negedge mclk);
    `CHK("done pulse", 1'b0, sym_done)
    for (i = 0; i < 3000 && far.k <= last; i++) @(negedge mclk);
    limit(i, 3000);
    `CHK("pilots", pil, far.n_pilot)
    `CHK("data cells", last - 2 - pil, far.n_data)
    `CHK("reserved", 3, far.n_rsv)
    `CHK("cell values", 0, far.n_bad)
    `CHK("data count", last - 2 - pil, p2_data_cell_count)
    if (!fl[2])
    begin
      `CHK("regular", last / sp + 1, regular_pilot_count)
      `CHK("padding", 2 * ex, pad_carrier_count)
      `CHK("pad extra", 2 * ex - 2 * ex / sp, extra_pad_pilot_count)
    end
    sa = sb;
    sb = far.neg;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    `CHK("idle", 2'h0, {busy, cell_valid})
    sym(FFT_1K, 6'h00, LAST_1K, EXT_NONE, P2_SPACING_STD);
    sym(FFT_1K, 6'h08, LAST_1K, EXT_NONE, P2_SPACING_STD);
    pd = 0;
    for (int k = 0; k <= LAST_1K; k += P2_SPACING_STD) pd += (sa[k] ^ sb[k]) !== k / 3 % 2;
    `CHK("p2 inversion", 0, pd)
    // extended request below 8k runs as normal; miso partner and edge pilots
    sym(FFT_1K, 6'h30, LAST_1K, EXT_NONE, P2_SPACING_STD);
    sym(FFT_1K, 6'h04, LAST_1K, EXT_NONE, 5'h0C);
    sym(FFT_1K, 6'h0E, LAST_1K, EXT_NONE, 5'h0C);
    `CHK("fc inversion", 2'h2, {sa[12] ^ sb[12], sa[24] ^ sb[24]})
    `CHK("edge override", sa[0] ^ sa[LAST_1K], sb[0] ^ sb[LAST_1K])
    sym(FFT_1K, 6'h0F, LAST_1K, EXT_NONE, 5'h0C);
    `CHK("edge alternate", 3'h6, {sa[0] ^ sb[0], sa[LAST_1K] ^ sb[LAST_1K], sa[12] ^ sb[12]})
    sym(FFT_2K, 6'h00, LAST_2K, EXT_NONE, P2_SPACING_STD);
    sym(FFT_4K, 6'h10, LAST_4K, EXT_NONE, P2_SPACING_STD);
    sym(FFT_8K, 6'h00, LAST_8K, EXT_NONE, P2_SPACING_STD);
    pd = far.n_data;
    sym(FFT_8K, 6'h20, LAST_8K + 2 * EXT_8K, EXT_8K, P2_SPACING_STD);
    `CHK("same capacity", pd, far.n_data)
    pd = 0;
    for (int k = 0; k <= LAST_8K; k += P2_SPACING_STD) pd += sa[k] !== sb[k + EXT_8K];
    `CHK("sequence align", 0, pd)
    sym(FFT_32K, 6'h00, LAST_32K, EXT_NONE, P2_SPACING_WIDE);
    // largest boost on the widest band
    sym(FFT_32K, 6'h30, LAST_32K + 2 * EXT_32K, EXT_32K, P2_SPACING_STD);
    `CHK("miso regular", REG_32K_MISO_E, regular_pilot_count)
    give_verdict();
  end
endmodule
